// ==== rtl/hpw_pkg.sv ====
/*
 * Shared constants and types for the halt, power-down and watchdog block.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package hpw_pkg;

    // System clock rate
    localparam int CLK_HZ = 10_000_000;

    // Register byte offsets on the bus
    localparam logic [7:0] ADR_WATCHDOG_CONTROL  = 8'h00;  // watchdog_control
    localparam logic [7:0] ADR_SCC   = 8'h04;  // system_clock_ctrl_reg keep bits
    localparam logic [7:0] ADR_STAT  = 8'h08;  // power_down_flag, watchdog_expired_flag
    localparam logic [7:0] ADR_RSTF  = 8'h0C;  // reset_flag_reg
    localparam logic [7:0] ADR_PORT_A_WAKE_ENABLE  = 8'h10;  // port_a_wake_enable

    // Field positions
    localparam int KEY_MSB       = 7;
    localparam int KEY_LSB       = 3;
    localparam int SEL_MSB       = 2;
    localparam int FAST_KEEP_BIT = 1;
    localparam int SLOW_KEEP_BIT = 0;
    localparam int EXPD_BIT      = 0;
    localparam int PDF_BIT       = 1;
    localparam int KEYRF_BIT     = 0;

    // Reset values and key codes
    localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h53;
    localparam logic [1:0] KEEP_RST = 2'h0;
    localparam logic [4:0] KEY_DIS  = 5'h15;
    localparam logic [4:0] KEY_EN   = 5'h0A;

    // Timing: soft reset delay and oscillator settle time after wake
    localparam int SRESET_US     = 50;
    localparam int SRST_CYC      = (SRESET_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int OSC_SETTLE_US = 20;
    localparam int SETTLE_CYC    = (OSC_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;

    // Operating modes
    typedef enum logic [2:0] {
        MD_RUN,
        MD_SLEEP,
        MD_IDLE0,
        MD_IDLE1,
        MD_IDLE2,
        MD_WAKE
    } hpw_mode_t;

    // What happens when wake settling ends
    typedef enum logic [1:0] {
        WK_RESUME,
        WK_SERVICE,
        WK_PCSP
    } hpw_wake_t;

    // Terminal count for each period select code
    function automatic logic [17:0] wdt_top(input logic [2:0] sel);
        case (sel)
            3'h0:    return 18'h0_00FF;
            3'h1:    return 18'h0_03FF;
            3'h2:    return 18'h0_0FFF;
            3'h3:    return 18'h0_3FFF;
            3'h4:    return 18'h0_7FFF;
            3'h5:    return 18'h0_FFFF;
            3'h6:    return 18'h1_FFFF;
            default: return 18'h3_FFFF;
        endcase
    endfunction

endpackage

// ==== rtl/hpw_ctrl.sv ====
/*
 * Halt power-down controller with watchdog, clock gating enables and wake logic.
 * Assumes the core pulses halt_i and clear_watchdog_instr_i for one cycle, the interrupt
 * logic drives request, enable and stack-full levels on clk_i, and port A,
 * the slow oscillator and the oscillator-stable signal arrive asynchronously.
 */
// Register access over Wishbone and the register offsets are this design's own decisions.
// Summary of operation
// - Halt with both keep bits low enters SLEEP; only the watchdog keeps running.
// - Halt with fast keep 0, slow keep 1 enters IDLE0: fast off, slow on.
// - Halt with both keep bits high enters IDLE1: both clocks on, CPU stopped.
// - Halt with fast keep 1, slow keep 0 enters IDLE2: fast on, slow off.
// - Power-down stops execution; memory, registers and ports hold their state.
// - Entering any power-down mode sets the power-down flag, clears expired flag.
// - Halt clears the watchdog counter; it keeps counting only when enabled.
// - Wake on enabled port A falling edge, system interrupt or watchdog overflow.
// - Power-down flag set by halt, cleared only by power-up or clear-watchdog.
// - Overflow while powered down sets expired flag, resets only PC and stack pointer.
// - Per-pin wake enables; a pin wake resumes after the halt instruction.
// - Disabled interrupt or full stack resumes after halt; else normal service.
// - Interrupt already flagged before halt is not a wake source.
// - After wake, hold the CPU until the oscillator restarts and settles.
// - Watchdog counts slow oscillator periods, divided by the period select.
// - Key 10101 disables the watchdog, key 01010 enables it.
// - Any other key resets the device after a delay and sets key-reset flag.
// - Period codes 0 to 7 give 2^8,10,12,14,15,16,17,18 slow periods.
// - Overflow in normal operation resets the device and sets expired flag.
// - Software clears the watchdog periodically with the clear-watchdog instruction.
`timescale 1ns/1ps
`default_nettype none

module hpw_ctrl #(
    parameter int PA_W  = 8,
    parameter int IRQ_W = 8
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Core and interrupt logic
    input  wire logic              halt_i,
    input  wire logic              clear_watchdog_instr_i,
    input  wire logic [IRQ_W-1:0]  irq_req_i,
    input  wire logic [IRQ_W-1:0]  irq_en_i,
    input  wire logic              stack_full_i,
    // Asynchronous inputs
    input  wire logic [PA_W-1:0]   port_a_i,
    input  wire logic              slow_osc_i,
    input  wire logic              osc_stable_i,
    // Clock enables, resets and wake pulses
    output logic                   fast_clk_en_o,
    output logic                   low_clk_en_o,
    output logic                   cpu_run_o,
    output logic                   wdt_clk_en_o,
    output logic                   dev_reset_o,
    output logic                   pc_sp_reset_o,
    output logic                   resume_o,
    output logic                   irq_take_o
);

    localparam int SRST_CHK = hpw_pkg::SRST_CYC;

    typedef struct packed {
        logic [7:0]        watchdog_control;
        logic [1:0]        keep;
        logic [PA_W-1:0]   port_a_wake_enable;
        logic              power_down_flag;
        logic              expd;
        logic              keyrf;
        hpw_pkg::hpw_mode_t mode;
        hpw_pkg::hpw_wake_t wake;
        logic [17:0]       wdt_cnt;
        logic              osc_s1;
        logic              osc_s2;
        logic              osc_s3;
        logic              ok_s1;
        logic              ok_s2;
        logic [PA_W-1:0]   pa_s1;
        logic [PA_W-1:0]   pa_s2;
        logic [PA_W-1:0]   pa_s3;
        logic [IRQ_W-1:0]  blocked;
        logic              srst_busy;
        logic [15:0]       srst_cnt;
        logic [15:0]       settle_cnt;
        logic [31:0]       dat;
        logic              ack;
        logic              fast_en;
        logic              low_en;
        logic              cpu_run;
        logic              wdt_run;
        logic              dev_rst;
        logic              pcsp_rst;
        logic              resume;
        logic              irq_take;
    } hpw_state_t;

    hpw_state_t q;
    hpw_state_t d;

    logic              bus_req;
    logic              bus_wr;
    logic              tick;
    logic              wdt_en;
    logic              key_bad;
    logic              ovf;
    logic              pd_mode;
    logic              halt_go;
    logic [PA_W-1:0]   pa_fall;
    logic [IRQ_W-1:0]  irq_new;
    logic              irq_wake;

    // Decoded conditions shared by the next-state logic and the checks
    assign bus_req  = wb_cyc_i & wb_stb_i & ~q.ack;
    assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
    assign tick     = q.osc_s2 & ~q.osc_s3;
    assign wdt_en   = q.watchdog_control[hpw_pkg::KEY_MSB:hpw_pkg::KEY_LSB] == hpw_pkg::KEY_EN;
    assign key_bad  = !wdt_en && (q.watchdog_control[hpw_pkg::KEY_MSB:hpw_pkg::KEY_LSB] != hpw_pkg::KEY_DIS);
    assign ovf      = wdt_en & tick
                      & (q.wdt_cnt == hpw_pkg::wdt_top(q.watchdog_control[hpw_pkg::SEL_MSB:0]));
    assign pd_mode  = (q.mode == hpw_pkg::MD_SLEEP) || (q.mode == hpw_pkg::MD_IDLE0)
                      || (q.mode == hpw_pkg::MD_IDLE1) || (q.mode == hpw_pkg::MD_IDLE2);
    assign halt_go  = halt_i && (q.mode == hpw_pkg::MD_RUN);
    // Falling edge seen only after two sync stages; the first stage feeds nothing else
    assign pa_fall  = q.pa_s3 & ~q.pa_s2 & q.port_a_wake_enable;
    // Requests already flagged at halt entry cannot wake the part
    assign irq_new  = irq_req_i & ~q.blocked;
    assign irq_wake = |irq_new;

    // Next-state logic for the whole block
    always_comb begin
        d          = q;
        d.ack      = 1'b0;
        d.dev_rst  = 1'b0;
        d.pcsp_rst = 1'b0;
        d.resume   = 1'b0;
        d.irq_take = 1'b0;

        // Two-stage synchronisers, third stage only for edge detection
        d.osc_s1 = slow_osc_i;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.ok_s1  = osc_stable_i;
        d.ok_s2  = q.ok_s1;
        d.pa_s1  = port_a_i;
        d.pa_s2  = q.pa_s1;
        d.pa_s3  = q.pa_s2;

        // Bus slave: one-cycle answer, unmapped reads return zero
        d.ack = bus_req;
        if (bus_req) begin
            case (wb_adr_i)
                hpw_pkg::ADR_WATCHDOG_CONTROL: d.dat = {24'h00_0000, q.watchdog_control};
                hpw_pkg::ADR_SCC:  d.dat = {30'h0000_0000, q.keep};
                hpw_pkg::ADR_STAT: d.dat = {30'h0000_0000, q.power_down_flag, q.expd};
                hpw_pkg::ADR_RSTF: d.dat = {31'h0000_0000, q.keyrf};
                hpw_pkg::ADR_PORT_A_WAKE_ENABLE: d.dat = {{(32-PA_W){1'b0}}, q.port_a_wake_enable};
                default:           d.dat = 32'h0000_0000;
            endcase
        end
        if (bus_wr) begin
            case (wb_adr_i)
                hpw_pkg::ADR_WATCHDOG_CONTROL: d.watchdog_control = wb_dat_i[7:0];
                hpw_pkg::ADR_SCC:  d.keep = wb_dat_i[1:0];
                hpw_pkg::ADR_RSTF: begin
                    if (!wb_dat_i[hpw_pkg::KEYRF_BIT]) begin
                        d.keyrf = 1'b0; // Software may only clear it
                    end
                end
                hpw_pkg::ADR_PORT_A_WAKE_ENABLE: d.port_a_wake_enable = wb_dat_i[PA_W-1:0];
                default: ;
            endcase
        end

        // Watchdog counter: clear on instruction or halt, count slow ticks when enabled
        if (clear_watchdog_instr_i || halt_go) begin
            d.wdt_cnt = 18'h0_0000;
        end else if (wdt_en && tick) begin
            d.wdt_cnt = ovf ? 18'h0_0000 : q.wdt_cnt + 18'h0_0001;
        end

        // Clear-watchdog clears the power-down flag; a halt in the same cycle wins
        if (clear_watchdog_instr_i) begin
            d.power_down_flag = 1'b0;
        end

        // Mode machine
        case (q.mode)
            hpw_pkg::MD_RUN: begin
                if (halt_i) begin
                    d.power_down_flag     = 1'b1;
                    d.expd    = 1'b0;
                    d.blocked = irq_req_i;
                    case ({q.keep[hpw_pkg::FAST_KEEP_BIT], q.keep[hpw_pkg::SLOW_KEEP_BIT]})
                        2'b00:   d.mode = hpw_pkg::MD_SLEEP;
                        2'b01:   d.mode = hpw_pkg::MD_IDLE0;
                        2'b11:   d.mode = hpw_pkg::MD_IDLE1;
                        default: d.mode = hpw_pkg::MD_IDLE2;
                    endcase
                end
            end
            hpw_pkg::MD_SLEEP, hpw_pkg::MD_IDLE0, hpw_pkg::MD_IDLE1, hpw_pkg::MD_IDLE2: begin
                if (ovf || (|pa_fall) || irq_wake) begin
                    d.mode       = hpw_pkg::MD_WAKE;
                    d.settle_cnt = 16'h0000;
                    if (ovf) begin
                        d.wake = hpw_pkg::WK_PCSP;
                    end else if (irq_wake && (|(irq_new & irq_en_i)) && !stack_full_i) begin
                        d.wake = hpw_pkg::WK_SERVICE;
                    end else begin
                        d.wake = hpw_pkg::WK_RESUME;
                    end
                end
            end
            hpw_pkg::MD_WAKE: begin
                // Hold the core until the oscillator reports stable and has settled
                if (!q.ok_s2) begin
                    d.settle_cnt = 16'h0000;
                end else if (q.settle_cnt != 16'(hpw_pkg::SETTLE_CYC - 1)) begin
                    d.settle_cnt = q.settle_cnt + 16'h0001;
                end else begin
                    d.mode = hpw_pkg::MD_RUN;
                    case (q.wake)
                        hpw_pkg::WK_PCSP:    d.pcsp_rst = 1'b1;
                        hpw_pkg::WK_SERVICE: d.irq_take = 1'b1;
                        default:             d.resume   = 1'b1;
                    endcase
                end
            end
            default: d.mode = hpw_pkg::MD_RUN;
        endcase

        // Overflow: full reset when running, flag only otherwise; set wins over clear
        if (ovf) begin
            d.expd = 1'b1;
            if (q.mode == hpw_pkg::MD_RUN) begin
                d.dev_rst = 1'b1;
            end
        end

        // Bad key: wait the soft reset delay, then reset and restore the control word
        if (q.srst_busy) begin
            if (q.srst_cnt == 16'(hpw_pkg::SRST_CYC - 1)) begin
                d.srst_busy = 1'b0;
                d.dev_rst   = 1'b1;
                d.keyrf     = 1'b1;
                d.watchdog_control      = hpw_pkg::WATCHDOG_CONTROL_RST;
                d.wdt_cnt   = 18'h0_0000;
                d.mode      = hpw_pkg::MD_RUN;
            end else begin
                d.srst_cnt = q.srst_cnt + 16'h0001;
            end
        end else if (key_bad) begin
            d.srst_busy = 1'b1;
            d.srst_cnt  = 16'h0000;
        end

        // Registered enables follow the next mode and watchdog key so they line up with them
        d.cpu_run = d.mode == hpw_pkg::MD_RUN;
        d.fast_en = (d.mode == hpw_pkg::MD_RUN) || (d.mode == hpw_pkg::MD_WAKE)
                    || (d.mode == hpw_pkg::MD_IDLE1) || (d.mode == hpw_pkg::MD_IDLE2);
        d.low_en  = (d.mode == hpw_pkg::MD_RUN) || (d.mode == hpw_pkg::MD_WAKE)
                    || (d.mode == hpw_pkg::MD_IDLE0) || (d.mode == hpw_pkg::MD_IDLE1);
        d.wdt_run = d.watchdog_control[hpw_pkg::KEY_MSB:hpw_pkg::KEY_LSB] == hpw_pkg::KEY_EN;
    end

    // State register; pins idle high so no false edge leaves reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q         <= '0;
            q.watchdog_control    <= hpw_pkg::WATCHDOG_CONTROL_RST;
            q.keep    <= hpw_pkg::KEEP_RST;
            q.mode    <= hpw_pkg::MD_RUN;
            q.wake    <= hpw_pkg::WK_RESUME;
            q.pa_s1   <= '1;
            q.pa_s2   <= '1;
            q.pa_s3   <= '1;
            q.fast_en <= 1'b1;
            q.low_en  <= 1'b1;
            q.cpu_run <= 1'b1;
            q.wdt_run <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o      = q.dat;
    assign wb_ack_o      = q.ack;
    assign fast_clk_en_o = q.fast_en;
    assign low_clk_en_o  = q.low_en;
    assign cpu_run_o     = q.cpu_run;
    assign wdt_clk_en_o  = q.wdt_run;
    assign dev_reset_o   = q.dev_rst;
    assign pc_sp_reset_o = q.pcsp_rst;
    assign resume_o      = q.resume;
    assign irq_take_o    = q.irq_take;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_halt_keep(logic [1:0] k);
        halt_go && !q.srst_busy && (q.keep == k);
    endsequence
    property p_sleep;
        s_halt_keep(2'b00) |=> !fast_clk_en_o && !low_clk_en_o && !cpu_run_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
    property p_idle0;
        s_halt_keep(2'b01) |=> !fast_clk_en_o && low_clk_en_o && !cpu_run_o;
    endproperty
    a_idle0: assert property (p_idle0) else $error("idle0 clocks wrong");
    property p_idle1;
        s_halt_keep(2'b11) |=> fast_clk_en_o && low_clk_en_o && !cpu_run_o;
    endproperty
    a_idle1: assert property (p_idle1) else $error("idle1 clocks wrong");
    property p_idle2;
        s_halt_keep(2'b10) |=> fast_clk_en_o && !low_clk_en_o && !cpu_run_o;
    endproperty
    a_idle2: assert property (p_idle2) else $error("idle2 clocks wrong");
    property p_halt_flags;
        halt_go && !ovf |=> q.power_down_flag && !q.expd && (q.wdt_cnt == 18'h0_0000);
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
    property p_pdf_clear;
        clear_watchdog_instr_i && !halt_go |=> !q.power_down_flag;
    endproperty
    a_pdf_clear: assert property (p_pdf_clear) else $error("pdf not cleared");
    property p_pd_ovf;
        pd_mode && ovf |=> q.expd && (q.mode == hpw_pkg::MD_WAKE) && (q.wake == hpw_pkg::WK_PCSP);
    endproperty
    a_pd_ovf: assert property (p_pd_ovf) else $error("sleep overflow wrong");
    property p_run_ovf;
        (q.mode == hpw_pkg::MD_RUN) && ovf |=> dev_reset_o && q.expd;
    endproperty
    a_run_ovf: assert property (p_run_ovf) else $error("run overflow no reset");
    property p_pin_wake;
        pd_mode && (|pa_fall) && !q.srst_busy |=> q.mode == hpw_pkg::MD_WAKE;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");
    property p_no_old_irq;
        pd_mode && !irq_wake && !(|pa_fall) && !ovf && !q.srst_busy |=> $stable(q.mode);
    endproperty
    a_no_old_irq: assert property (p_no_old_irq) else $error("spurious wake");
    property p_settle;
        (q.mode == hpw_pkg::MD_WAKE) && !q.ok_s2 |=> !cpu_run_o;
    endproperty
    a_settle: assert property (p_settle) else $error("woke before stable");
    property p_wdt_off;
        !wdt_en && !halt_go && !clear_watchdog_instr_i |=> $stable(q.wdt_cnt) || dev_reset_o;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog moved");
    sequence s_bad_key;
        $rose(q.srst_busy);
    endsequence
    property p_key_reset;
        s_bad_key |-> ##[1:SRST_CHK] (dev_reset_o && q.keyrf);
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("key reset missing");

endmodule

`default_nettype wire

// ==== bench/hpw_core_model.sv ====
/*
 * Core model that issues the halt and clear-watchdog instruction strobes.
 * Assumes the bench calls its tasks from one process and clk_i is the
 * system clock of the power-down block.
 */
`timescale 1ns/1ps
`default_nettype none

module hpw_core_model (
    // Clock
    input  wire logic clk_i,
    // Run state from the power-down block
    input  wire logic cpu_run_i,
    // Instruction strobes
    output logic      halt_o,
    output logic      clear_watchdog_instr_o
);
    // Strobes stay low until an instruction is asked for
    initial begin
        halt_o    = 1'b0;
        clear_watchdog_instr_o = 1'b0;
    end

    // A stopped core fetches nothing, so a halt only issues while running
    task automatic do_halt();
        @(posedge clk_i);
        halt_o <= cpu_run_i;
        @(posedge clk_i);
        halt_o <= 1'b0;
    endtask

    // Software path that zeroes the watchdog; a halt issued while running zeroes it too
    task automatic do_clr();
        @(posedge clk_i);
        clear_watchdog_instr_o <= 1'b1;
        @(posedge clk_i);
        clear_watchdog_instr_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== bench/halt_power_down_and_watchdog_test.sv ====
/*
 * Self-checking bench for the halt, power-down and watchdog block.
 * Assumes the register map, pulse outputs and settle counts of the package;
 * the slow oscillator runs free at eight system clocks per period.
 */
`timescale 1ns/1ps
`default_nettype none

module halt_power_down_and_watchdog_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack, halt, clr, fast_en, low_en, cpu_run, wdt_en;
    logic        dev_rst, pcsp, resume, take;
    logic [7:0]  irq_req = 8'h00, irq_en = 8'h00, port_a = 8'hFF;
    logic        stack_full = 1'b0, slow_osc = 1'b0, osc_ok = 1'b1;
    logic [3:0]  pls;
    logic [3:0]  sel = 4'h1;
    logic [31:0] expq[$];
    logic [7:0]  radr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0]  rexp[6] = '{8'h53, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int          miscompares = 0, checks = 0, n;
    integer      seed;
    logic [2:0]  pin;

    hpw_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .halt_i(halt), .clear_watchdog_instr_i(clr), .irq_req_i(irq_req), .irq_en_i(irq_en),
        .stack_full_i(stack_full), .port_a_i(port_a), .slow_osc_i(slow_osc),
        .osc_stable_i(osc_ok), .fast_clk_en_o(fast_en), .low_clk_en_o(low_en),
        .cpu_run_o(cpu_run), .wdt_clk_en_o(wdt_en), .dev_reset_o(dev_rst),
        .pc_sp_reset_o(pcsp), .resume_o(resume), .irq_take_o(take));
    hpw_core_model core (.clk_i(clk_i), .cpu_run_i(cpu_run), .halt_o(halt), .clear_watchdog_instr_o(clr));

    // Pulse outputs as one vector: reset, pc/sp reset, resume, irq take
    assign pls = {dev_rst, pcsp, resume, take};

    // System clock and a free-running slow oscillator of unrelated phase
    initial forever #50 clk_i = ~clk_i;
    initial begin
        #37;
        forever #400 slow_osc = ~slow_osc;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic ok(input string nm, input logic c);
        chk(nm, 32'h0000_0001, {31'h0, c});
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard: about twice the planned run length
    initial begin
        #4_000_000;
        miscompares++;
        end_of_test();
    end

    // Monitor: any result not announced in the queue meets a sentinel and fails
    task automatic take_note(input string nm, input logic [31:0] g);
        logic [31:0] e;
        e = 32'hDEAD_BEEF;
        if (expq.size() > 0) e = expq.pop_front();
        chk(nm, e, g);
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) take_note("read data", rdat);
        // Outputs are unknown until the first reset edge, so pulses count only after it
        if (pls !== 4'h0 && rst_i === 1'b0) take_note("pulses", {28'h0, pls});
    end

    // Classic single Wishbone cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic [31:0] r;
        k = 0;
        r = $random(seed);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= {r[3:1], 1'b1}; // Upper lanes are don't-care for 8-bit registers
        wdat <= {r[31:8], d[7:0]};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        ok("bus ack", k == 2);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Wait for a pulse; n holds the cycles waited
    task automatic wait_pulse(input int lim);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pls === 4'h0 && n < lim);
        if (n >= lim) ok("pulse wait", 1'b0);
    endtask

    // Falling edge on the enabled pin, resume after halt once settled
    task automatic pin_wake();
        expq.push_back(32'h0000_0002);
        @(posedge clk_i);
        port_a[pin] <= 1'b0;
        osc_ok      <= 1'b0;
        // Oscillator reports stable late, so the settle count must start after it
        repeat (30) @(posedge clk_i);
        osc_ok <= 1'b1;
        wait_pulse(1000);
        ok("settle hold", n > hpw_pkg::SETTLE_CYC);
        port_a[pin] <= 1'b1;
    endtask

    // Main sequence
    initial begin
        seed = 32'he101_b5a2;
        pin = 3'($random(seed));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (radr[i]) rd(radr[i], {24'h0, rexp[i]});
        $display("test reset values done");
        bus(1'b1, hpw_pkg::ADR_PORT_A_WAKE_ENABLE, 32'(8'h01 << pin));
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, hpw_pkg::ADR_SCC, 32'(k));
            core.do_halt();
            repeat (2) @(posedge clk_i);
            ok("fast clock enable", fast_en === k[1]);
            ok("low clock enable", low_en === k[0]);
            ok("cpu stopped", cpu_run === 1'b0);
            rd(hpw_pkg::ADR_STAT, 32'h0000_0002);
            pin_wake();
            core.do_clr();
            rd(hpw_pkg::ADR_STAT, 32'h0000_0000);
        end
        $display("test halt modes done");
        irq_req <= 8'h01;
        for (int k = 0; k < 3; k++) begin
            irq_en <= (k == 2) ? 8'h7F : 8'hFF;
            stack_full <= (k == 1);
            core.do_halt();
            repeat (50) @(posedge clk_i);
            ok("old flag no wake", cpu_run === 1'b0);
            expq.push_back((k == 0) ? 32'h0000_0001 : 32'h0000_0002);
            irq_req <= 8'h81;
            wait_pulse(1000);
            irq_req <= 8'h01;
        end
        @(posedge clk_i);
        irq_req <= 8'h00;
        $display("test interrupt wake done");
        bus(1'b1, hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_00A8);
        @(posedge clk_i);
        ok("watchdog off", wdt_en === 1'b0);
        rd(hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_00A8);
        bus(1'b1, hpw_pkg::ADR_SCC, 32'h0000_0000);
        core.do_halt();
        repeat (3000) @(posedge clk_i);
        pin_wake();
        $display("test disabled watchdog done");
        bus(1'b1, hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_0050);
        @(posedge clk_i);
        ok("watchdog on", wdt_en === 1'b1);
        repeat (3) begin
            repeat (1500) @(posedge clk_i);
            core.do_clr();
        end
        repeat (1500) @(posedge clk_i);
        expq.push_back(32'h0000_0004);
        core.do_halt();
        wait_pulse(4000);
        ok("sleep timeout", n >= 2220 && n <= 2290);
        rd(hpw_pkg::ADR_STAT, 32'h0000_0003);
        $display("test sleep overflow done");
        bus(1'b1, hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_0051);
        core.do_clr();
        expq.push_back(32'h0000_0008);
        wait_pulse(9000);
        ok("run timeout", n >= 8170 && n <= 8230);
        rd(hpw_pkg::ADR_STAT, 32'h0000_0001);
        $display("test run overflow done");
        core.do_clr();
        expq.push_back(32'h0000_0008);
        bus(1'b1, hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_0000);
        wait_pulse(1000);
        ok("key delay", n >= hpw_pkg::SRST_CYC - 3 && n <= hpw_pkg::SRST_CYC + 3);
        rd(hpw_pkg::ADR_RSTF, 32'h0000_0001);
        rd(hpw_pkg::ADR_WATCHDOG_CONTROL, 32'h0000_0053);
        bus(1'b1, hpw_pkg::ADR_RSTF, 32'h0000_0000);
        rd(hpw_pkg::ADR_RSTF, 32'h0000_0000);
        $display("test bad key done");
        end_of_test();
    end
endmodule

`default_nettype wire
